// ==== verilog/ltld_pkg.sv ====
// Function
// - Six digital lines, each holding its own mode.
// - Line one: trigger in, high, low, sense.
// - Line two: output, input, high, low, sense.
// - Line three: fault out, high, low, sense.
// - Lines four to six: output, input, high, low, sense.
// - Voltage qualify bit cleared ignores voltage.
// - Current qualify bit cleared ignores current.
// - Voltage level compared against every voltage sample.
// - Current level compared against every current sample.
// - Voltage rise fires above, fall below level.
// - Current rise fires above, fall below level.
// - Pre-trigger count sets samples kept before trigger.
// - Arming empties buffer, starts continuous fill.
// - Firing keeps pre-trigger samples, starts post fill.
// - Armed indicator output high while armed.
// - Readable flag reports a trigger has fired.
// - High limit reached drives selected output lines.
// - Low limit reached drives selected output lines.
// - Buffer holds at most 2500 samples.
`default_nettype none
package ltld_pkg;
	localparam logic [11:0] LTLD_DEPTH = 12'h9c4;
	localparam logic [11:0] LTLD_ONE = 12'h001;
	localparam int LTLD_LINES = 6;
	localparam int LTLD_MW = 3;
	localparam int LTLD_DW = 16;
	// Register byte addresses.
	localparam logic [7:0] LTLD_A_CTRL = 8'h00;
	localparam logic [7:0] LTLD_A_VLVL = 8'h04;
	localparam logic [7:0] LTLD_A_ILVL = 8'h08;
	localparam logic [7:0] LTLD_A_PRE = 8'h0c;
	localparam logic [7:0] LTLD_A_STAT = 8'h10;
	localparam logic [7:0] LTLD_A_MODE = 8'h14;
	localparam logic [7:0] LTLD_A_LACT = 8'h18;
	localparam logic [7:0] LTLD_A_HVL = 8'h1c;
	localparam logic [7:0] LTLD_A_LVL = 8'h20;
	localparam logic [7:0] LTLD_A_DIO = 8'h24;
	localparam logic [7:0] LTLD_A_BIDX = 8'h28;
	localparam logic [7:0] LTLD_A_BDAT = 8'h2c;
	// Field positions.
	localparam int LTLD_ARM_B = 0;
	localparam int LTLD_VQ_B = 1;
	localparam int LTLD_IQ_B = 2;
	localparam int LTLD_VDIR_B = 3;
	localparam int LTLD_IDIR_B = 4;
	localparam int LTLD_CTRL_W = 5;
	localparam int LTLD_ST_MODE_L = 2;
	localparam int LTLD_ST_CNT_L = 16;
	localparam int LTLD_LV_ACT_L = 8;
	localparam int LTLD_DIN_L = 8;
	localparam int LTLD_ST_OCC_B = 0;
	localparam int LTLD_ST_ARM_B = 1;

	typedef enum logic [2:0] {
		M_TRIG_IN = 3'b000,
		M_GOUT = 3'b001,
		M_GIN = 3'b010,
		M_DHIGH = 3'b011,
		M_DLOW = 3'b100,
		M_MSENSE = 3'b101,
		M_FAULT = 3'b110
	} ltld_mode_t;

	typedef enum logic [1:0] {
		B_IDLE = 2'b00,
		B_CONT = 2'b01,
		B_POST = 2'b10,
		B_DONE = 2'b11
	} ltld_buf_t;

	typedef struct packed {
		logic [LTLD_DW-1:0] volt;
		logic [LTLD_DW-1:0] curr;
	} ltld_sample_t;

	localparam ltld_mode_t LTLD_MODE_RST = M_MSENSE;

	// Line index counts from zero: line one is index 0.
	function automatic logic ltld_legal(input int line, input ltld_mode_t m);
		case (m)
			M_DHIGH, M_DLOW, M_MSENSE: ltld_legal = 1'b1;
			M_TRIG_IN: ltld_legal = (line == 0);
			M_FAULT: ltld_legal = (line == 2);
			M_GOUT, M_GIN: ltld_legal = (line != 0) && (line != 2);
			default: ltld_legal = 1'b0;
		endcase
	endfunction

	function automatic logic [31:0] ltld_merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] sel);
		ltld_merge = old;
		for (int b = 0; b < 4; b++)
		begin
			if (sel[b])
				ltld_merge[8*b +: 8] = nw[8*b +: 8];
		end
	endfunction
endpackage
`default_nettype wire

// ==== verilog/ltld_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module ltld_top (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic rst,
	// Wishbone slave.
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Measurement sampler.
	input wire logic smp_valid,
	input wire ltld_pkg::ltld_sample_t smp,
	// Digital lines and indicators.
	input wire logic fault_in,
	input wire logic [ltld_pkg::LTLD_LINES-1:0] dio_in,
	output logic [ltld_pkg::LTLD_LINES-1:0] dio_out,
	output logic [ltld_pkg::LTLD_LINES-1:0] dio_oe,
	output logic armed_ind
);
	import ltld_pkg::*;

	logic ack_q;
	logic [31:0] dat_q;
	logic [31:0] rd_d;
	logic [31:0] wv;
	logic take;
	logic wr_go;
	logic [LTLD_CTRL_W-1:0] ctrl_q;
	logic [LTLD_DW-1:0] vlvl_q;
	logic [LTLD_DW-1:0] ilvl_q;
	logic [LTLD_DW-1:0] hv_q;
	logic [LTLD_DW-1:0] lv_q;
	logic [11:0] pre_q;
	logic [11:0] bidx_q;
	logic [11:0] cnt_q;
	logic [11:0] wr_q;
	logic [11:0] keep_n;
	logic [11:0] cnt_inc;
	logic [11:0] rd_ix;
	logic [12:0] rd_sum;
	logic [LTLD_LINES-1:0] hv_act_q;
	logic [LTLD_LINES-1:0] lv_act_q;
	logic [LTLD_LINES-1:0] dout_q;
	logic [LTLD_LINES*LTLD_MW-1:0] mode_pack;
	ltld_mode_t mode_q [LTLD_LINES];
	ltld_buf_t bmode_q;
	logic occ_q;
	logic hv_hit_q;
	logic lv_hit_q;
	logic arm_rise;
	logic arm_fall;
	logic v_hit;
	logic i_hit;
	logic cap;
	logic fire;
	ltld_sample_t mem [int'(LTLD_DEPTH)];

	// ----------------------------------------
	// Bus slave
	// ----------------------------------------

	// A request is taken on the first cycle; ack follows one cycle later and
	// writes land on the edge at which the master sees ack.
	assign take = cyc_i && stb_i && !ack_q;
	assign wr_go = cyc_i && stb_i && we_i && ack_q;
	assign ack_o = ack_q;
	assign dat_o = dat_q;
	assign wv = ltld_merge(rd_d, dat_i, sel_i);

	always_comb
	begin
		for (int n = 0; n < LTLD_LINES; n++)
			mode_pack[n*LTLD_MW +: LTLD_MW] = mode_q[n];
	end

	always_comb
	begin
		rd_d = '0;
		case (adr_i)
			LTLD_A_CTRL: rd_d[LTLD_CTRL_W-1:0] = ctrl_q;
			LTLD_A_VLVL: rd_d[LTLD_DW-1:0] = vlvl_q;
			LTLD_A_ILVL: rd_d[LTLD_DW-1:0] = ilvl_q;
			LTLD_A_PRE: rd_d[11:0] = pre_q;
			LTLD_A_STAT:
			begin
				rd_d[LTLD_ST_OCC_B] = occ_q;
				rd_d[LTLD_ST_ARM_B] = ctrl_q[LTLD_ARM_B];
				rd_d[LTLD_ST_MODE_L +: 2] = bmode_q;
				rd_d[LTLD_ST_CNT_L +: 12] = cnt_q;
			end
			LTLD_A_MODE: rd_d[LTLD_LINES*LTLD_MW-1:0] = mode_pack;
			LTLD_A_LACT:
			begin
				rd_d[LTLD_LINES-1:0] = hv_act_q;
				rd_d[LTLD_LV_ACT_L +: LTLD_LINES] = lv_act_q;
			end
			LTLD_A_HVL: rd_d[LTLD_DW-1:0] = hv_q;
			LTLD_A_LVL: rd_d[LTLD_DW-1:0] = lv_q;
			LTLD_A_DIO:
			begin
				rd_d[LTLD_LINES-1:0] = dout_q;
				rd_d[LTLD_DIN_L +: LTLD_LINES] = dio_in;
			end
			LTLD_A_BIDX: rd_d[11:0] = bidx_q;
			LTLD_A_BDAT:
			begin
				if (bidx_q < cnt_q)
					rd_d = mem[rd_ix];
			end
			default: rd_d = '0;
		endcase
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			ack_q <= 1'b0;
			dat_q <= '0;
		end
		else
		begin
			ack_q <= take;
			if (take)
				dat_q <= rd_d;
		end
	end

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------

	assign arm_rise = wr_go && adr_i == LTLD_A_CTRL && wv[LTLD_ARM_B] && !ctrl_q[LTLD_ARM_B];
	assign arm_fall = wr_go && adr_i == LTLD_A_CTRL && !wv[LTLD_ARM_B] && ctrl_q[LTLD_ARM_B];

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			ctrl_q <= '0;
			vlvl_q <= '0;
			ilvl_q <= '0;
			pre_q <= '0;
			hv_q <= '0;
			lv_q <= '0;
			hv_act_q <= '0;
			lv_act_q <= '0;
			dout_q <= '0;
			bidx_q <= '0;
		end
		else if (wr_go)
		begin
			case (adr_i)
				LTLD_A_CTRL: ctrl_q <= wv[LTLD_CTRL_W-1:0];
				LTLD_A_VLVL: vlvl_q <= wv[LTLD_DW-1:0];
				LTLD_A_ILVL: ilvl_q <= wv[LTLD_DW-1:0];
				// Counts of the buffer depth or more are clamped to one below the depth it can hold.
				LTLD_A_PRE: pre_q <= (wv[11:0] >= LTLD_DEPTH) ? LTLD_DEPTH - LTLD_ONE : wv[11:0];
				LTLD_A_LACT:
				begin
					hv_act_q <= wv[LTLD_LINES-1:0];
					lv_act_q <= wv[LTLD_LV_ACT_L +: LTLD_LINES];
				end
				LTLD_A_HVL: hv_q <= wv[LTLD_DW-1:0];
				LTLD_A_LVL: lv_q <= wv[LTLD_DW-1:0];
				LTLD_A_DIO: dout_q <= wv[LTLD_LINES-1:0];
				LTLD_A_BIDX: bidx_q <= (wv[11:0] >= LTLD_DEPTH) ? LTLD_DEPTH - LTLD_ONE : wv[11:0];
				default: ;
			endcase
		end
	end

	// An illegal mode for a line is dropped and the line keeps its old mode.
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			for (int n = 0; n < LTLD_LINES; n++)
				mode_q[n] <= LTLD_MODE_RST;
		end
		else if (wr_go && adr_i == LTLD_A_MODE)
		begin
			for (int n = 0; n < LTLD_LINES; n++)
			begin
				if (ltld_legal(n, ltld_mode_t'(wv[n*LTLD_MW +: LTLD_MW])))
					mode_q[n] <= ltld_mode_t'(wv[n*LTLD_MW +: LTLD_MW]);
			end
		end
	end

	// ----------------------------------------
	// Level trigger
	// ----------------------------------------

	assign v_hit = ctrl_q[LTLD_VQ_B] && (ctrl_q[LTLD_VDIR_B] ? smp.volt > vlvl_q : smp.volt < vlvl_q);
	assign i_hit = ctrl_q[LTLD_IQ_B] && (ctrl_q[LTLD_IDIR_B] ? smp.curr > ilvl_q : smp.curr < ilvl_q);
	assign cap = smp_valid && (bmode_q == B_CONT || bmode_q == B_POST) && !arm_rise && !arm_fall;
	assign fire = cap && bmode_q == B_CONT && !occ_q && (v_hit || i_hit);
	assign armed_ind = ctrl_q[LTLD_ARM_B];

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			occ_q <= 1'b0;
		else if (arm_rise)
			occ_q <= 1'b0;
		else if (fire)
			occ_q <= 1'b1;
	end

	// ----------------------------------------
	// Sample buffer
	// ----------------------------------------

	assign cnt_inc = (cnt_q == LTLD_DEPTH) ? LTLD_DEPTH : cnt_q + LTLD_ONE;
	assign keep_n = ((cnt_q > pre_q) ? pre_q : cnt_q) + LTLD_ONE;

	// The triggering sample itself is stored as the first post-trigger one.
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			wr_q <= '0;
			cnt_q <= '0;
			bmode_q <= B_IDLE;
		end
		else if (arm_rise)
		begin
			cnt_q <= '0;
			bmode_q <= B_CONT;
		end
		else if (arm_fall)
			bmode_q <= B_IDLE;
		else if (cap)
		begin
			wr_q <= (wr_q == LTLD_DEPTH - LTLD_ONE) ? '0 : wr_q + LTLD_ONE;
			if (fire)
			begin
				cnt_q <= keep_n;
				bmode_q <= (keep_n == LTLD_DEPTH) ? B_DONE : B_POST;
			end
			else
			begin
				cnt_q <= cnt_inc;
				if (bmode_q == B_POST && cnt_inc == LTLD_DEPTH)
					bmode_q <= B_DONE;
			end
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (cap)
			mem[wr_q] <= smp;
	end

	// Index zero of the read window is the oldest sample kept.
	always_comb
	begin
		rd_sum = 13'(wr_q) + 13'(bidx_q) + 13'(LTLD_DEPTH - cnt_q);
		if (rd_sum >= {LTLD_DEPTH, 1'b0})
			rd_ix = 12'(rd_sum - {LTLD_DEPTH, 1'b0});
		else if (rd_sum >= 13'(LTLD_DEPTH))
			rd_ix = 12'(rd_sum - 13'(LTLD_DEPTH));
		else
			rd_ix = rd_sum[11:0];
	end

	// ----------------------------------------
	// Voltage limits and digital lines
	// ----------------------------------------

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			hv_hit_q <= 1'b0;
			lv_hit_q <= 1'b0;
		end
		else if (smp_valid)
		begin
			hv_hit_q <= smp.volt >= hv_q;
			lv_hit_q <= smp.volt <= lv_q;
		end
	end

	for (genvar g = 0; g < LTLD_LINES; g++)
	begin : g_line
		always_ff @(posedge core_clk or posedge rst)
		begin
			if (rst)
			begin
				dio_out[g] <= 1'b0;
				dio_oe[g] <= 1'b0;
			end
			else
			begin
				case (mode_q[g])
					M_GOUT:
					begin
						dio_oe[g] <= 1'b1;
						dio_out[g] <= dout_q[g] || (hv_act_q[g] && hv_hit_q) || (lv_act_q[g] && lv_hit_q);
					end
					M_DHIGH:
					begin
						dio_oe[g] <= 1'b1;
						dio_out[g] <= 1'b1;
					end
					M_DLOW:
					begin
						dio_oe[g] <= 1'b1;
						dio_out[g] <= 1'b0;
					end
					M_FAULT:
					begin
						dio_oe[g] <= 1'b1;
						dio_out[g] <= fault_in;
					end
					default:
					begin
						dio_oe[g] <= 1'b0;
						dio_out[g] <= 1'b0;
					end
				endcase
			end
		end

		property p_mode_legal;
			@(posedge core_clk) disable iff (rst)
			ltld_legal(g, mode_q[g]);
		endproperty
		a_mode_legal: assert property (p_mode_legal) else $error("line mode illegal");

		property p_hv_drive;
			@(posedge core_clk) disable iff (rst)
			(mode_q[g] == M_GOUT && hv_act_q[g] && hv_hit_q) |=> (dio_oe[g] && dio_out[g]);
		endproperty
		a_hv_drive: assert property (p_hv_drive) else $error("high limit not driven");

		property p_lv_drive;
			@(posedge core_clk) disable iff (rst)
			(mode_q[g] == M_GOUT && lv_act_q[g] && lv_hit_q) |=> (dio_oe[g] && dio_out[g]);
		endproperty
		a_lv_drive: assert property (p_lv_drive) else $error("low limit not driven");
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------

	property p_arm_clear;
		@(posedge core_clk) disable iff (rst)
		arm_rise |=> (cnt_q == '0 && bmode_q == B_CONT && !occ_q && armed_ind);
	endproperty
	a_arm_clear: assert property (p_arm_clear) else $error("arming did not clear buffer");

	property p_fire_post;
		@(posedge core_clk) disable iff (rst)
		fire |=> (occ_q && (bmode_q == B_POST || bmode_q == B_DONE));
	endproperty
	a_fire_post: assert property (p_fire_post) else $error("fire did not start post fill");

	property p_pre_keep;
		@(posedge core_clk) disable iff (rst)
		(fire && cnt_q >= pre_q) |=> cnt_q == $past(pre_q) + LTLD_ONE;
	endproperty
	a_pre_keep: assert property (p_pre_keep) else $error("pre-trigger count wrong");

	property p_occ_hold;
		@(posedge core_clk) disable iff (rst)
		(occ_q && !arm_rise) |=> occ_q;
	endproperty
	a_occ_hold: assert property (p_occ_hold) else $error("fired flag dropped");

	property p_qualify;
		@(posedge core_clk) disable iff (rst)
		fire |-> (ctrl_q[LTLD_VQ_B] || ctrl_q[LTLD_IQ_B]);
	endproperty
	a_qualify: assert property (p_qualify) else $error("fire with no qualify bit");

	property p_v_rise;
		@(posedge core_clk) disable iff (rst)
		(cap && bmode_q == B_CONT && ctrl_q[LTLD_VQ_B] && ctrl_q[LTLD_VDIR_B] && smp.volt > vlvl_q)
			|=> occ_q;
	endproperty
	a_v_rise: assert property (p_v_rise) else $error("voltage rise missed");

	property p_i_fall;
		@(posedge core_clk) disable iff (rst)
		(cap && bmode_q == B_CONT && ctrl_q[LTLD_IQ_B] && !ctrl_q[LTLD_IDIR_B] && smp.curr < ilvl_q)
			|=> occ_q;
	endproperty
	a_i_fall: assert property (p_i_fall) else $error("current fall missed");

	property p_depth;
		@(posedge core_clk) disable iff (rst)
		cnt_q <= LTLD_DEPTH && pre_q < LTLD_DEPTH;
	endproperty
	a_depth: assert property (p_depth) else $error("buffer count past depth");
endmodule
`default_nettype wire

// ==== verif/ltld_sampler_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module ltld_sampler_model (
	// Clock.
	input wire logic core_clk,
	// Sample stream.
	output logic smp_valid,
	output ltld_pkg::ltld_sample_t smp,
	// External line levels.
	output logic [5:0] dio_in
);
	import ltld_pkg::*;
	initial
	begin
		smp_valid = 1'b0;
		smp = '0;
		dio_in = 6'h00;
	end
	// One sample for one cycle; the idle bus then shows the inverse so stale data is not reused.
	// An idle cycle follows, so back-to-back calls never drive valid twice in one step.
	task automatic send(input logic [15:0] v, input logic [15:0] c);
		smp_valid <= 1'b1;
		smp <= '{volt: v, curr: c};
		@(posedge core_clk);
		smp_valid <= 1'b0;
		smp <= ~{v, c};
		@(posedge core_clk);
	endtask
	task automatic lines(input logic [5:0] d);
		dio_in <= d;
	endtask
endmodule
`default_nettype wire

// ==== verif/level_trigger_logger_dio_test.sv ====
`timescale 1ns/1ns
`default_nettype none
module level_trigger_logger_dio_test;
	import ltld_pkg::*;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [3:0] sel_w = 4'hf;
	logic [31:0] dat = 32'h0;
	logic fault_in = 1'b0;
	logic [31:0] rdat, r, w, modes;
	logic ack, smp_valid, armed_ind;
	ltld_sample_t smp;
	logic [5:0] dio_in, dio_out, dio_oe;
	logic [6:0] ok [6] = '{7'h39, 7'h3e, 7'h78, 7'h3e, 7'h3e, 7'h3e};
	int lim [4] = '{3000, 500, 2999, 501};
	int mismatches = 0;
	int comparisons = 0;
	int cycles = 0;
	int q[$];
	int bm = 0, occ = 0, pre = 0, arm = 0, ctl = 0, v, c;
	bit vq, iq, d;

	ltld_top dut_u (.core_clk(core_clk), .rst(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
		.adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(rdat), .ack_o(ack),
		.smp_valid(smp_valid), .smp(smp), .fault_in(fault_in), .dio_in(dio_in),
		.dio_out(dio_out), .dio_oe(dio_oe), .armed_ind(armed_ind));
	ltld_sampler_model smp_u (.core_clk(core_clk), .smp_valid(smp_valid), .smp(smp),
		.dio_in(dio_in));

	always #5 core_clk = ~core_clk;
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			mismatches++;
			test_done();
		end
	end

	task automatic test_done();
		$display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			mismatches++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] dt);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= wr;
		adr <= a;
		dat <= dt;
		sel <= sel_w;
		@(posedge core_clk);
		while (ack !== 1'b1 && n < 20)
		begin
			@(posedge core_clk);
			n++;
		end
		r = rdat;
		if (n == 20)
			chk(32'h1, 32'h0);
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(r, e);
	endtask
	// ------
	// Reference model.
	// ------
	function automatic logic [31:0] stx();
		stx = (q.size() << 16) | (bm << 2) | (arm << 1) | occ;
	endfunction
	function automatic bit hit(input int sv, input int sc);
		hit = (ctl[1] && (ctl[3] ? sv > 1000 : sv < 1000))
			|| (ctl[2] && (ctl[4] ? sc > 1000 : sc < 1000));
	endfunction
	function automatic int pick(input bit fire, input bit rise);
		int x;
		x = $urandom % 1000;
		pick = rise ? (fire ? 1001 + x : 1 + x) : (fire ? x : 1000 + x);
	endfunction
	task automatic setc(input int cv);
		if (cv[0] && !arm)
		begin
			q.delete();
			occ = 0;
			bm = 1;
		end
		if (!cv[0])
			bm = 0;
		arm = cv & 1;
		ctl = cv;
		wb(1'b1, LTLD_A_CTRL, cv);
	endtask
	task automatic samp(input int sv, input int sc);
		if (bm == 1 && hit(sv, sc))
		begin
			while (q.size() > pre)
				void'(q.pop_front());
			occ = 1;
			bm = 2;
		end
		if (bm == 1 || bm == 2)
			q.push_back((sv << 16) | (sc & 'hffff));
		if (q.size() > 2500)
			void'(q.pop_front());
		if (bm == 2 && q.size() == 2500)
			bm = 3;
		smp_u.send(sv[15:0], sc[15:0]);
	endtask

	initial
	begin
		void'($urandom(33002));
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		chk(dio_oe, 6'h00);
		chk(armed_ind, 1'b0);
		modes = 32'h2db6d;
		rd(LTLD_A_MODE, modes);
		rd(8'h30, 32'h0);
		for (int l = 0; l < 6; l++)
			for (int m = 0; m < 7; m++)
			begin
				w = modes;
				w[3*l +: 3] = 3'(m);
				wb(1'b1, LTLD_A_MODE, w);
				if (ok[l][m])
					modes = w;
				rd(LTLD_A_MODE, modes);
			end
		wb(1'b1, LTLD_A_VLVL, 32'hffffffff);
		sel_w = 4'h1;
		wb(1'b1, LTLD_A_VLVL, 32'h000000e8);
		sel_w = 4'h2;
		wb(1'b1, LTLD_A_VLVL, 32'h00000300);
		sel_w = 4'hf;
		rd(LTLD_A_VLVL, 32'd1000);
		wb(1'b1, LTLD_A_ILVL, 32'd1000);
		rd(LTLD_A_ILVL, 32'd1000);
		for (int k = 0; k < 5; k++)
		begin
			vq = (k < 2) || (k == 4);
			iq = (k > 1);
			d = (k % 2 == 0);
			pre = $urandom % 6;
			wb(1'b1, LTLD_A_PRE, pre);
			setc(1 + vq * 2 + iq * 4 + d * 24);
			rd(LTLD_A_STAT, stx());
			chk(armed_ind, 1'b1);
			repeat (3 + $urandom % 6)
				samp(vq ? pick(0, d) : $urandom % 65536, iq ? pick(0, d) : $urandom % 65536);
			rd(LTLD_A_STAT, stx());
			v = (k < 2) ? pick(1, d) : (k == 4 ? pick(0, d) : $urandom % 65536);
			c = (k < 2) ? $urandom % 65536 : pick(1, d);
			samp(v, c);
			rd(LTLD_A_STAT, stx());
			samp(v, c);
			rd(LTLD_A_STAT, stx());
			wb(1'b1, LTLD_A_BIDX, 32'h0);
			rd(LTLD_A_BDAT, q[0]);
			wb(1'b1, LTLD_A_BIDX, q.size());
			rd(LTLD_A_BDAT, 32'h0);
			setc(0);
			rd(LTLD_A_STAT, stx());
			chk(armed_ind, 1'b0);
		end
		wb(1'b1, LTLD_A_PRE, 32'hbb8);
		pre = 2499;
		rd(LTLD_A_PRE, pre);
		setc(11);
		repeat (2505)
			samp(pick(0, 1), 0);
		rd(LTLD_A_STAT, stx());
		samp(pick(1, 1), 0);
		rd(LTLD_A_STAT, stx());
		setc(0);
		modes = 32'h2338d;
		wb(1'b1, LTLD_A_MODE, modes);
		wb(1'b1, LTLD_A_HVL, 32'hbb8);
		wb(1'b1, LTLD_A_LVL, 32'h1f4);
		wb(1'b1, LTLD_A_LACT, 32'h802);
		rd(LTLD_A_HVL, 32'hbb8);
		rd(LTLD_A_LVL, 32'h1f4);
		rd(LTLD_A_LACT, 32'h802);
		wb(1'b1, LTLD_A_DIO, 32'h0);
		setc(1);
		foreach (lim[i])
		begin
			fault_in <= i[0];
			samp(lim[i], 0);
			repeat (2) @(posedge core_clk);
			w = ((lim[i] >= 3000) << 1) | (i[0] << 2) | ((lim[i] <= 500) << 3) | 16;
			chk(dio_oe, 6'h3e);
			chk(dio_out & 6'h3e, w);
		end
		w = $urandom % 64;
		smp_u.lines(w[5:0]);
		repeat (2) @(posedge core_clk);
		rd(LTLD_A_DIO, w << 8);
		test_done();
	end
endmodule
`default_nettype wire
